// ---- rtl/kpc_regs.svh ----
// constants for the keypad controller two-wire register port
`ifndef KPC_REGS_SVH
`define KPC_REGS_SVH

`define KPC_ADDR7_BYTE   8'h88
`define KPC_ADDR10       10'h088
`define KPC_HDR10        5'h1E
`define KPC_HDR10_HI     2'h0
`define KPC_GCALL_BYTE   8'h00
`define KPC_DEVID_ADDR   7'h7C
`define KPC_FIFO_PORT    8'h10
`define KPC_BYTE_BITS    4'h8
`define KPC_ACK_SLOT     4'h9

`endif

// ---- rtl/kpc_pkg.sv ----
// types for the keypad controller two-wire register port
package kpc_pkg;

	typedef enum logic [2:0] {
		KPC_ST_IDLE,
		KPC_ST_ADDR,
		KPC_ST_ADDR2,
		KPC_ST_INDEX,
		KPC_ST_WDATA,
		KPC_ST_RDATA,
		KPC_ST_RACK
	} kpc_state_t;

	typedef enum logic [1:0] {
		KPC_EV_END,
		KPC_EV_WR,
		KPC_EV_RD
	} kpc_event_t;

endpackage

// ---- rtl/kpc_i2c_port.sv ----
// keypad controller two-wire slave register port
//
// How it works
// - a word register changes only when both bytes arrive in one transfer
// - reading a write-only register returns zero
// - slave only; host keeps the clock at or below fast rate
// - direction bit after the address: zero write, one read
// - the device acknowledges every byte it accepts
// - first byte after a write address loads the address pointer
// - each new index byte after a repeated start reloads the pointer
// - own address is acknowledged even while the system clock sleeps
// - the interrupt line is pulled low to request service
// - pointer advances by one after every data byte written or acknowledged by the host, except at the key event fifo port
// - first data byte after the index is stored at the pointer
// - general call reset is ignored
// - device identification query gets no answer
// - both 7-bit and 10-bit addressing are recognised
// - top two bits of the 10-bit address are fixed at zero
// - in a read the pointer advances on each master acknowledge, except at the key event fifo port
// - every cycle to the own address is acknowledged while halted
// - the key event fifo port does not auto-increment
`timescale 1ns/1ps
`include "kpc_regs.svh"

module kpc_i2c_port #(
	parameter logic [255:0] WORD_MAP  = 256'h0,
	parameter logic [255:0] WO_MAP    = 256'h0,
	parameter logic [7:0]   FIFO_ADDR = `KPC_FIFO_PORT
) (
	// system clock and reset
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	// link clock
	input  wire logic        link_clk_in,
	// two-wire bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n_out,
	// host interrupt pin
	input  wire logic        irq_req_in,
	output logic             host_interrupt_line_out,
	output logic             host_interrupt_line_oe_n_out,
	// register bank write side
	output logic             reg_wr_out,
	output logic             reg_wr_word_out,
	output logic [7:0]       reg_wr_addr_out,
	output logic [15:0]      reg_wr_data_out,
	// register bank read side
	output logic             reg_rd_out,
	output logic [7:0]       reg_rd_addr_out,
	input  wire logic [7:0]  reg_rd_data_in
);
	import kpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link domain: reset and pin synchronisers

	logic        lrst_s1_reg;
	logic        lrst_reg;
	logic        scl_s1_reg;
	logic        scl_s2_reg;
	logic        scl_d_reg;
	logic        sda_s1_reg;
	logic        sda_s2_reg;
	logic        sda_d_reg;

	always_ff @(posedge link_clk_in) begin
		lrst_s1_reg <= sys_rst_in;
		lrst_reg    <= lrst_s1_reg;
	end

	always_ff @(posedge link_clk_in) begin
		scl_s1_reg <= scl_in;
		scl_s2_reg <= scl_s1_reg;
		sda_s1_reg <= sda_in;
		sda_s2_reg <= sda_s1_reg;
		if (lrst_reg) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s2_reg;
			sda_d_reg <= sda_s2_reg;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// sda only moves while scl is low, so our own drive never looks like a start
	assign scl_rise  = scl_s2_reg & ~scl_d_reg;
	assign scl_fall  = ~scl_s2_reg & scl_d_reg;
	assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// link domain: read data coming back from the system side

	logic        rd_tgl_reg;
	logic        rdt_s1_reg;
	logic        rdt_s2_reg;
	logic        rdt_d_reg;
	logic [7:0]  rd_data_reg;
	logic [7:0]  rd_byte_reg;

	always_ff @(posedge link_clk_in) begin
		rdt_s1_reg <= rd_tgl_reg;
		rdt_s2_reg <= rdt_s1_reg;
		if (lrst_reg) begin
			rdt_d_reg   <= 1'b0;
			rd_byte_reg <= 8'h00;
		end else begin
			rdt_d_reg <= rdt_s2_reg;
			if (rdt_s2_reg ^ rdt_d_reg)
				rd_byte_reg <= rd_data_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: bus state machine, pointer and events

	kpc_state_t  st_reg;
	kpc_state_t  after_reg;
	logic [3:0]  cnt_reg;
	logic [7:0]  sh_reg;
	logic        sda_low_reg;
	logic [7:0]  ptr_reg;
	logic        ten_sel_reg;
	logic        ev_tgl_reg;
	kpc_event_t  ev_kind_reg;
	logic [7:0]  ev_addr_reg;
	logic [7:0]  ev_data_reg;
	logic [7:0]  ptr_next;
	logic        receiving;
	logic        is_read;
	logic [7:0]  addr2_byte;

	assign ptr_next   = (ptr_reg == FIFO_ADDR) ? ptr_reg : ptr_reg + 8'h01;
	assign receiving  = (st_reg == KPC_ST_ADDR) || (st_reg == KPC_ST_ADDR2) ||
	                    (st_reg == KPC_ST_INDEX) || (st_reg == KPC_ST_WDATA);
	assign is_read    = sh_reg[0];
	assign addr2_byte = 8'(`KPC_ADDR10);

	always_ff @(posedge link_clk_in) begin
		if (lrst_reg) begin
			st_reg      <= KPC_ST_IDLE;
			after_reg   <= KPC_ST_IDLE;
			cnt_reg     <= 4'h0;
			sh_reg      <= 8'h00;
			sda_low_reg <= 1'b0;
			ptr_reg     <= 8'h00;
			ten_sel_reg <= 1'b0;
			ev_tgl_reg  <= 1'b0;
			ev_kind_reg <= KPC_EV_END;
			ev_addr_reg <= 8'h00;
			ev_data_reg <= 8'h00;
		end else if (stop_det) begin
			st_reg      <= KPC_ST_IDLE;
			sda_low_reg <= 1'b0;
			ten_sel_reg <= 1'b0;
			ev_kind_reg <= KPC_EV_END;
			ev_tgl_reg  <= ~ev_tgl_reg;
		end else if (start_det) begin
			st_reg      <= KPC_ST_ADDR;
			cnt_reg     <= 4'h0;
			sda_low_reg <= 1'b0;
			ev_kind_reg <= KPC_EV_END;
			ev_tgl_reg  <= ~ev_tgl_reg;
		end else if (scl_rise && st_reg != KPC_ST_IDLE) begin
			if (st_reg == KPC_ST_RACK) begin
				if (sda_s2_reg) begin
					st_reg <= KPC_ST_IDLE;
				end else begin
					ptr_reg     <= ptr_next;
					ev_kind_reg <= KPC_EV_RD;
					ev_addr_reg <= ptr_next;
					ev_tgl_reg  <= ~ev_tgl_reg;
				end
			end else if (receiving && cnt_reg < `KPC_BYTE_BITS) begin
				sh_reg  <= {sh_reg[6:0], sda_s2_reg};
				cnt_reg <= cnt_reg + 4'h1;
			end
		end else if (scl_fall && st_reg != KPC_ST_IDLE) begin
			if (cnt_reg == `KPC_ACK_SLOT || st_reg == KPC_ST_RACK) begin
				// end of an acknowledge slot: release, or go straight to data out
				if (after_reg == KPC_ST_RDATA || st_reg == KPC_ST_RACK) begin
					sda_low_reg <= ~rd_byte_reg[7];
					sh_reg      <= {rd_byte_reg[6:0], 1'b1};
					cnt_reg     <= 4'h1;
					st_reg      <= KPC_ST_RDATA;
				end else begin
					sda_low_reg <= 1'b0;
					cnt_reg     <= 4'h0;
					st_reg      <= after_reg;
				end
			end else if (st_reg == KPC_ST_RDATA) begin
				if (cnt_reg < `KPC_BYTE_BITS) begin
					sda_low_reg <= ~sh_reg[7];
					sh_reg      <= {sh_reg[6:0], 1'b1};
					cnt_reg     <= cnt_reg + 4'h1;
				end else begin
					sda_low_reg <= 1'b0;
					st_reg      <= KPC_ST_RACK;
				end
			end else if (receiving && cnt_reg == `KPC_BYTE_BITS) begin
				// ack does not depend on the system clock running
				sda_low_reg <= 1'b1;
				cnt_reg     <= `KPC_ACK_SLOT;
				unique case (st_reg)
					KPC_ST_ADDR: begin
						if (sh_reg == `KPC_GCALL_BYTE || sh_reg[7:1] == `KPC_DEVID_ADDR) begin
							sda_low_reg <= 1'b0;
							st_reg      <= KPC_ST_IDLE;
						end else if ({sh_reg[7:1], 1'b0} == `KPC_ADDR7_BYTE) begin
							ten_sel_reg <= 1'b0;
							after_reg   <= is_read ? KPC_ST_RDATA : KPC_ST_INDEX;
						end else if (sh_reg[7:1] == {`KPC_HDR10, `KPC_HDR10_HI} && (!is_read || ten_sel_reg)) begin
							after_reg <= is_read ? KPC_ST_RDATA : KPC_ST_ADDR2;
						end else begin
							sda_low_reg <= 1'b0;
							st_reg      <= KPC_ST_IDLE;
						end
						if (is_read && ({sh_reg[7:1], 1'b0} == `KPC_ADDR7_BYTE ||
						                (sh_reg[7:1] == {`KPC_HDR10, `KPC_HDR10_HI} && ten_sel_reg))) begin
							ev_kind_reg <= KPC_EV_RD;
							ev_addr_reg <= ptr_reg;
							ev_tgl_reg  <= ~ev_tgl_reg;
						end
					end
					KPC_ST_ADDR2: begin
						if (sh_reg == addr2_byte) begin
							ten_sel_reg <= 1'b1;
							after_reg   <= KPC_ST_INDEX;
						end else begin
							sda_low_reg <= 1'b0;
							st_reg      <= KPC_ST_IDLE;
						end
					end
					KPC_ST_INDEX: begin
						ptr_reg   <= sh_reg;
						after_reg <= KPC_ST_WDATA;
					end
					KPC_ST_WDATA: begin
						ev_kind_reg <= KPC_EV_WR;
						ev_addr_reg <= ptr_reg;
						ev_data_reg <= sh_reg;
						ev_tgl_reg  <= ~ev_tgl_reg;
						ptr_reg     <= ptr_next;
						after_reg   <= KPC_ST_WDATA;
					end
					default: begin
						sda_low_reg <= 1'b0;
						st_reg      <= KPC_ST_IDLE;
					end
				endcase
			end
		end
	end

	// open drain: low level only, enable low while pulling
	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~sda_low_reg;

	////////////////////////////////////////////////////////////////////////
	// system domain: event receiver
	// event fields are held until the next toggle, which is at least an acknowledge slot away

	logic        ev_s1_reg;
	logic        ev_s2_reg;
	logic        ev_d_reg;
	logic        ev_new;
	logic        rd_pend_reg;
	logic        lo_valid_reg;
	logic [7:0]  lo_addr_reg;
	logic [7:0]  lo_data_reg;

	always_ff @(posedge mclk_in) begin
		ev_s1_reg <= ev_tgl_reg;
		ev_s2_reg <= ev_s1_reg;
		if (sys_rst_in)
			ev_d_reg <= 1'b0;
		else
			ev_d_reg <= ev_s2_reg;
	end

	assign ev_new = ev_s2_reg ^ ev_d_reg;

	// word assembly: low byte at even index, high byte commits
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reg_wr_out      <= 1'b0;
			reg_wr_word_out <= 1'b0;
			reg_wr_addr_out <= 8'h00;
			reg_wr_data_out <= 16'h0000;
			lo_valid_reg    <= 1'b0;
			lo_addr_reg     <= 8'h00;
			lo_data_reg     <= 8'h00;
		end else begin
			reg_wr_out <= 1'b0;
			if (ev_new && ev_kind_reg == KPC_EV_END) begin
				lo_valid_reg <= 1'b0;
			end else if (ev_new && ev_kind_reg == KPC_EV_WR) begin
				if (WORD_MAP[ev_addr_reg] && !ev_addr_reg[0]) begin
					lo_valid_reg <= 1'b1;
					lo_addr_reg  <= ev_addr_reg;
					lo_data_reg  <= ev_data_reg;
				end else if (WORD_MAP[ev_addr_reg]) begin
					lo_valid_reg <= 1'b0;
					if (lo_valid_reg && lo_addr_reg == {ev_addr_reg[7:1], 1'b0}) begin
						reg_wr_out      <= 1'b1;
						reg_wr_word_out <= 1'b1;
						reg_wr_addr_out <= lo_addr_reg;
						reg_wr_data_out <= {ev_data_reg, lo_data_reg};
					end
				end else begin
					lo_valid_reg    <= 1'b0;
					reg_wr_out      <= 1'b1;
					reg_wr_word_out <= 1'b0;
					reg_wr_addr_out <= ev_addr_reg;
					reg_wr_data_out <= {8'h00, ev_data_reg};
				end
			end
		end
	end

	// read request, data taken the cycle after the strobe
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reg_rd_out      <= 1'b0;
			reg_rd_addr_out <= 8'h00;
			rd_pend_reg     <= 1'b0;
			rd_data_reg     <= 8'h00;
			rd_tgl_reg      <= 1'b0;
		end else begin
			reg_rd_out  <= ev_new && ev_kind_reg == KPC_EV_RD;
			rd_pend_reg <= reg_rd_out;
			if (ev_new && ev_kind_reg == KPC_EV_RD)
				reg_rd_addr_out <= ev_addr_reg;
			if (rd_pend_reg) begin
				rd_data_reg <= WO_MAP[reg_rd_addr_out] ? 8'h00 : reg_rd_data_in;
				rd_tgl_reg  <= ~rd_tgl_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host interrupt line, open drain

	logic irq_reg;

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_req_in;
	end

	assign host_interrupt_line_out      = 1'b0;
	assign host_interrupt_line_oe_n_out = ~irq_reg;

endmodule

// ---- sim/kpc_i2c_port_chk.sv ----
// assertion checker for the keypad two-wire register port
`timescale 1ns/1ps
module kpc_i2c_port_chk #(
	parameter logic [255:0] WORD_MAP = 256'h0
) (
	// clocks and reset
	input wire logic        mclk_in,
	input wire logic        sys_rst_in,
	input wire logic        link_clk_in,
	// bus and interrupt pins
	input wire logic        scl_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n_out,
	input wire logic        irq_req_in,
	input wire logic        host_interrupt_line_out,
	input wire logic        host_interrupt_line_oe_n_out,
	// register bank side
	input wire logic        reg_wr_out,
	input wire logic        reg_wr_word_out,
	input wire logic [7:0]  reg_wr_addr_out,
	input wire logic [15:0] reg_wr_data_out,
	input wire logic        reg_rd_out,
	input wire logic [7:0]  reg_rd_addr_out
);
	////////////////////////////////////////
	sequence s_req_on;
		irq_req_in ##1 irq_req_in;
	endsequence
	sequence s_req_off;
		!irq_req_in ##1 !irq_req_in;
	endsequence
	property p_irq_on;
		@(posedge mclk_in) disable iff (sys_rst_in) s_req_on |-> !host_interrupt_line_oe_n_out;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("irq line not low");
	property p_irq_off;
		@(posedge mclk_in) disable iff (sys_rst_in) s_req_off |-> host_interrupt_line_oe_n_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq line still low");
	property p_wr_gap;
		@(posedge mclk_in) disable iff (sys_rst_in) reg_wr_out |=> !reg_wr_out [*8];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("write pulse too long");
	property p_rd_gap;
		@(posedge mclk_in) disable iff (sys_rst_in) reg_rd_out |=> !reg_rd_out [*8];
	endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("read pulse too long");
	property p_byte_wr;
		@(posedge mclk_in) disable iff (sys_rst_in) reg_wr_out && !reg_wr_word_out
			|-> reg_wr_data_out[15:8] == 8'h00 && !WORD_MAP[reg_wr_addr_out];
	endproperty
	a_byte_wr: assert property (p_byte_wr) else $error("bad byte write");
	property p_word_wr;
		@(posedge mclk_in) disable iff (sys_rst_in) reg_wr_out && reg_wr_word_out
			|-> !reg_wr_addr_out[0] && WORD_MAP[reg_wr_addr_out];
	endproperty
	a_word_wr: assert property (p_word_wr) else $error("bad word write");
	property p_rd_addr;
		@(posedge mclk_in) disable iff (sys_rst_in) $changed(reg_rd_addr_out) |-> reg_rd_out;
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("read index moved");
	property p_excl;
		@(posedge mclk_in) disable iff (sys_rst_in) reg_wr_out |-> !reg_rd_out;
	endproperty
	a_excl: assert property (p_excl) else $error("read and write together");
	property p_od;
		@(posedge mclk_in) disable iff (sys_rst_in) sda_out == 1'b0 && host_interrupt_line_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("pin drives high");
	// synced scl lags, so a long high phase must see sda held
	property p_ack_hold;
		@(posedge link_clk_in) disable iff (sys_rst_in) scl_in [*4] |=> $stable(sda_oe_n_out);
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda moved while scl high");
endmodule

bind kpc_i2c_port kpc_i2c_port_chk #(.WORD_MAP(WORD_MAP)) u_chk (
	.mclk_in                      (mclk_in),
	.sys_rst_in                   (sys_rst_in),
	.link_clk_in                  (link_clk_in),
	.scl_in                       (scl_in),
	.sda_out                      (sda_out),
	.sda_oe_n_out                 (sda_oe_n_out),
	.irq_req_in                   (irq_req_in),
	.host_interrupt_line_out      (host_interrupt_line_out),
	.host_interrupt_line_oe_n_out (host_interrupt_line_oe_n_out),
	.reg_wr_out                   (reg_wr_out),
	.reg_wr_word_out              (reg_wr_word_out),
	.reg_wr_addr_out              (reg_wr_addr_out),
	.reg_wr_data_out              (reg_wr_data_out),
	.reg_rd_out                   (reg_rd_out),
	.reg_rd_addr_out              (reg_rd_addr_out)
);

// ---- sim/kpc_host_model.sv ----
// host master model driving the two-wire bus
`timescale 1ns/1ps
module kpc_host_model (
	output logic      scl_out,
	output logic      sda_low_out,
	input  wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////
	// 2.5 us bit, scl low 1.5 us: exactly the fast rate
	task automatic bit_io(input logic b, output logic r);
		#900 sda_low_out = !b;
		#600 scl_out = 1'b1;
		#500 r = sda_in;
		#500 scl_out = 1'b0;
	endtask
	task automatic start();
		#900 sda_low_out = 1'b0;
		#300 scl_out = 1'b1;
		#600 sda_low_out = 1'b1;
		#600 scl_out = 1'b0;
	endtask
	task automatic stop();
		#900 sda_low_out = 1'b1;
		#600 scl_out = 1'b1;
		#600 sda_low_out = 1'b0;
		#900;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule

// ---- sim/keypad_ctrl_i2c_register_port_tb_top.sv ----
// testbench for the keypad two-wire register port
`timescale 1ns/1ps
module keypad_ctrl_i2c_register_port_tb_top;
	logic        mclk_in = 1'b0;
	logic        link_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        irq_req_in = 1'b0;
	logic        scl_in, sda_in, m_low, sda_out, sda_oe_n_out;
	logic        host_interrupt_line_out, host_interrupt_line_oe_n_out;
	logic        reg_wr_out, reg_wr_word_out, reg_rd_out;
	logic [7:0]  reg_wr_addr_out, reg_rd_addr_out, reg_rd_data_in;
	logic [15:0] reg_wr_data_out;
	logic [24:0] wq[$];
	int          n_errors = 0;
	int          samples_checked = 0;
	always #5 mclk_in = !mclk_in;
	initial #3.3 forever #6 link_clk_in = !link_clk_in;
	// open drain with pull-up
	assign sda_in = !(m_low || !sda_oe_n_out);
	assign reg_rd_data_in = reg_rd_addr_out ^ 8'h5A;
	always @(posedge mclk_in) if (reg_wr_out === 1'b1) wq.push_back({reg_wr_word_out, reg_wr_addr_out, reg_wr_data_out});
	kpc_host_model m (.scl_out(scl_in), .sda_low_out(m_low), .sda_in(sda_in));
	kpc_i2c_port #(.WORD_MAP(256'h30), .WO_MAP(256'h1_0000_0000)) uut (
		.mclk_in                      (mclk_in),
		.sys_rst_in                   (sys_rst_in),
		.link_clk_in                  (link_clk_in),
		.scl_in                       (scl_in),
		.sda_in                       (sda_in),
		.sda_out                      (sda_out),
		.sda_oe_n_out                 (sda_oe_n_out),
		.irq_req_in                   (irq_req_in),
		.host_interrupt_line_out      (host_interrupt_line_out),
		.host_interrupt_line_oe_n_out (host_interrupt_line_oe_n_out),
		.reg_wr_out                   (reg_wr_out),
		.reg_wr_word_out              (reg_wr_word_out),
		.reg_wr_addr_out              (reg_wr_addr_out),
		.reg_wr_data_out              (reg_wr_data_out),
		.reg_rd_out                   (reg_rd_out),
		.reg_rd_addr_out              (reg_rd_addr_out),
		.reg_rd_data_in               (reg_rd_data_in)
	);
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic addr(input logic [7:0] a, input logic exp);
		logic ack;
		m.start();
		m.wbyte(a, ack);
		chk("addr ack", ack, exp);
	endtask
	task automatic wr_b(input logic [7:0] d);
		logic ack;
		m.wbyte(d, ack);
		chk("data ack", ack, 1'b1);
	endtask
	task automatic rd_b(input logic nack, input logic [7:0] exp);
		logic [7:0] d;
		m.rbyte(nack, d);
		chk("read data", d, exp);
	endtask
	task automatic exp_wr(input logic [24:0] e);
		logic [24:0] g;
		g = wq.size() > 0 ? wq.pop_front() : 25'bx;
		chk("reg write", g, e);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_irq();
		@(posedge mclk_in) #1 irq_req_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 chk("irq low", host_interrupt_line_oe_n_out, 1'b0);
		irq_req_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1 chk("irq free", host_interrupt_line_oe_n_out, 1'b1);
	endtask
	task automatic t_write();
		addr(8'h88, 1'b1);
		wr_b(8'hFF);
		wr_b(8'h01);
		wr_b(8'h05);
		m.stop();
		exp_wr({1'b0, 8'hFF, 16'h0001});
		exp_wr({1'b0, 8'h00, 16'h0005});
	endtask
	task automatic t_read();
		addr(8'h88, 1'b1);
		wr_b(8'hAA);
		addr(8'h89, 1'b1);
		rd_b(1'b0, 8'hF0);
		rd_b(1'b1, 8'hF1);
		addr(8'h88, 1'b1);
		wr_b(8'h20);
		addr(8'h89, 1'b1);
		rd_b(1'b1, 8'h00);
		m.stop();
		chk("no write", wq.size(), 32'h0);
	endtask
	task automatic t_word();
		addr(8'h88, 1'b1);
		wr_b(8'h04);
		wr_b(8'h34);
		wr_b(8'h12);
		addr(8'h88, 1'b1);
		wr_b(8'h04);
		wr_b(8'h77);
		m.stop();
		exp_wr({1'b1, 8'h04, 16'h1234});
		chk("partial word", wq.size(), 32'h0);
	endtask
	task automatic t_fifo();
		addr(8'h88, 1'b1);
		wr_b(8'h10);
		wr_b(8'h11);
		wr_b(8'h22);
		m.stop();
		exp_wr({1'b0, 8'h10, 16'h0011});
		exp_wr({1'b0, 8'h10, 16'h0022});
	endtask
	task automatic t_refuse();
		logic [7:0] bad[3] = '{8'h00, 8'hF8, 8'h8A};
		foreach (bad[i]) begin
			addr(bad[i], 1'b0);
			m.stop();
		end
		chk("refused write", wq.size(), 32'h0);
	endtask
	task automatic t_ten();
		addr(8'hF2, 1'b0);
		m.stop();
		addr(8'hF0, 1'b1);
		wr_b(8'h88);
		wr_b(8'h40);
		wr_b(8'h9C);
		addr(8'hF1, 1'b1);
		rd_b(1'b1, 8'h1B);
		m.stop();
		exp_wr({1'b0, 8'h40, 16'h009C});
	endtask
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge mclk_in);
		#1 sys_rst_in = 1'b0;
		#200;
		t_irq();
		t_write();
		t_read();
		t_word();
		t_fifo();
		t_refuse();
		t_ten();
		finish_test();
	end
	// hang guard, just under the cycle budget
	initial begin
		#950000;
		n_errors++;
		finish_test();
	end
endmodule
